// file: nsl_pkg.sv
// Shared constants and types of the node status lamp and valve test block
package nsl_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SLOW_HALF_MS = 1000;
  localparam int unsigned FAST_PERIOD_MS = 250;
  localparam int unsigned TEST_HALF_MS = 1000;
  localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / 1000 * FAST_PERIOD_MS / 2;
  localparam int unsigned TEST_HALF_CYCLES = CLK_HZ / 1000 * TEST_HALF_MS;
  localparam logic [2:0] SETTLE_CYCLES = 3'h6;

  // Station numbers
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'h7D;
  localparam logic [7:0] TEST_STATION = 8'hC7;

  // Widths
  localparam int unsigned NUM_VALVES = 16;
  localparam int unsigned NUM_PINS = 19;
  localparam int unsigned DIAG_W = 6;
  localparam int unsigned EV_W = 6;

  // Register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_EVENT = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;

  // Status layout
  localparam int unsigned ST_LAMP_LSB = 0;
  localparam int unsigned ST_BUSY_BIT = 4;
  localparam int unsigned ST_MODE_LSB = 8;

  // Event bit positions
  localparam int unsigned EV_STATION = 0;
  localparam int unsigned EV_BUS = 1;
  localparam int unsigned EV_VLOW = 2;
  localparam int unsigned EV_CHAIN = 3;
  localparam int unsigned EV_TEST = 4;
  localparam int unsigned EV_FAIL = 5;

  // Control layout and reset values
  localparam int unsigned CTRL_VALVE_EN_BIT = 0;
  localparam logic CTRL_VALVE_EN_RST = 1'b0;
  localparam logic [EV_W-1:0] EV_RST = 6'h00;
  localparam logic [EV_W-1:0] MASK_RST = 6'h00;

  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_NORMAL,
    MODE_ARMED,
    MODE_TEST,
    MODE_FAIL
  } nsl_mode_t;
endpackage

// file: nsl_blink_if.sv
// Flash timebase carrier between the divider and the lamp logic
`timescale 1ns/1ps
`default_nettype none
interface nsl_blink_if;
  logic tick;
  logic level;
  modport src (output tick, output level);
  modport snk (input tick, input level);
endinterface
`default_nettype wire

// file: nsl_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module nsl_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, out_q, out_d;

  always_comb begin
    s1_d = i_async;
    s2_d = s1_q;
    s3_d = s2_q;
    // A bit moves only once stages two and three agree
    out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      out_q <= out_d;
    end
  end

  assign o_sync = out_q;
endmodule
`default_nettype wire

// file: nsl_blink.sv
// Half-period divider giving a toggle level and a tick on each toggle
`timescale 1ns/1ps
`default_nettype none
module nsl_blink #(
  parameter int unsigned HALF_CYCLES = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  nsl_blink_if.src o_blink
);
  localparam int unsigned CW = (HALF_CYCLES > 2) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d, tick_q, tick_d;

  always_comb begin
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    tick_d = 1'b0;
    if (!i_run) begin
      // Stopped divider restarts from a known phase
      cnt_d = '0;
      lvl_d = 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_d = '0;
      lvl_d = !lvl_q;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
      lvl_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
      tick_q <= tick_d;
    end
  end

  assign o_blink.tick = tick_q;
  assign o_blink.level = lvl_q;
endmodule
`default_nettype wire

// file: nsl_node_status.sv
// Node status lamps, valve self-test sequencer and register slave
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module nsl_node_status #(
  parameter int unsigned FAST_HALF_CYCLES = nsl_pkg::FAST_HALF_CYCLES,
  parameter int unsigned SLOW_HALF_CYCLES = nsl_pkg::SLOW_HALF_CYCLES,
  parameter int unsigned TEST_HALF_CYCLES = nsl_pkg::TEST_HALF_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_logic_supply_ok,
  input wire logic i_valve_v_ok,
  input wire logic i_valve_v_low,
  input wire logic [7:0] i_station_num,
  input wire logic i_dil1_on,
  input wire logic i_bus_dup_addr,
  input wire logic i_bus_link_fail,
  input wire logic i_cfg_mismatch,
  input wire logic i_startup_done,
  input wire logic i_branch_changed,
  input wire logic i_chain_broken,
  input wire logic i_test_fault,
  input wire logic [nsl_pkg::NUM_VALVES-1:0] i_valve_cmd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_lamp_bus_err,
  output logic o_lamp_logic,
  output logic o_lamp_valve,
  output logic o_lamp_branch,
  output logic [nsl_pkg::NUM_VALVES-1:0] o_valve_out,
  output logic o_busy,
  output logic [nsl_pkg::DIAG_W-1:0] o_diag_faults,
  output logic o_irq
);
  localparam int unsigned NV = nsl_pkg::NUM_VALVES;
  localparam int unsigned EW = nsl_pkg::EV_W;

  // Pin synchronisers
  logic [nsl_pkg::NUM_PINS-1:0] pins_s;
  logic logic_ok_s, v_ok_s, v_low_s, dil1_s, dup_s, link_s, cfg_s;
  logic started_s, branch_chg_s, chain_s, tfault_s;
  logic [7:0] station_s;

  nsl_sync #(.W(nsl_pkg::NUM_PINS)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_station_num, i_logic_supply_ok, i_valve_v_ok, i_valve_v_low, i_dil1_on, i_bus_dup_addr,
              i_bus_link_fail, i_cfg_mismatch, i_startup_done, i_branch_changed, i_chain_broken, i_test_fault}),
    .o_sync(pins_s)
  );

  assign {station_s, logic_ok_s, v_ok_s, v_low_s, dil1_s, dup_s, link_s, cfg_s,
          started_s, branch_chg_s, chain_s, tfault_s} = pins_s;

  // Flash timebases
  nsl_blink_if fast_b ();
  nsl_blink_if slow_b ();
  nsl_blink_if test_b ();

  nsl_blink #(.HALF_CYCLES(FAST_HALF_CYCLES)) u_fast (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(1'b1),
    .o_blink(fast_b)
  );

  nsl_blink #(.HALF_CYCLES(SLOW_HALF_CYCLES)) u_slow (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(1'b1),
    .o_blink(slow_b)
  );

  nsl_pkg::nsl_mode_t mode_q, mode_d;
  logic [2:0] settle_q, settle_d;

  // Test timebase only runs in test, so the first toggle is a full second after entry
  nsl_blink #(.HALF_CYCLES(TEST_HALF_CYCLES)) u_test (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(mode_q == nsl_pkg::MODE_TEST),
    .o_blink(test_b)
  );

  // Derived conditions
  logic station_bad, bus_fault, start_phase, start_fault;
  assign station_bad = (station_s < nsl_pkg::STATION_MIN) || (station_s > nsl_pkg::STATION_MAX);
  assign bus_fault = dup_s || link_s || cfg_s;
  assign start_phase = !started_s;
  assign start_fault = tfault_s || !logic_ok_s || !v_ok_s;

  // Self-test sequencer; only reset (power cycle) leaves test or fail
  always_comb begin
    mode_d = mode_q;
    settle_d = settle_q;
    unique case (mode_q)
      nsl_pkg::MODE_BOOT: begin
        // Switch straps are read once the synchronisers have filled
        if (settle_q == nsl_pkg::SETTLE_CYCLES) begin
          if (station_s == nsl_pkg::TEST_STATION && dil1_s) begin
            mode_d = nsl_pkg::MODE_ARMED;
          end else begin
            mode_d = nsl_pkg::MODE_NORMAL;
          end
        end else begin
          settle_d = settle_q + 3'h1;
        end
      end
      nsl_pkg::MODE_ARMED: begin
        if (start_fault) begin
          mode_d = nsl_pkg::MODE_FAIL;
        end else if (!dil1_s) begin
          mode_d = nsl_pkg::MODE_TEST;
        end
      end
      nsl_pkg::MODE_NORMAL: mode_d = nsl_pkg::MODE_NORMAL;
      nsl_pkg::MODE_TEST: mode_d = nsl_pkg::MODE_TEST;
      nsl_pkg::MODE_FAIL: mode_d = nsl_pkg::MODE_FAIL;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode_q <= nsl_pkg::MODE_BOOT;
      settle_q <= 3'h0;
    end else begin
      mode_q <= mode_d;
      settle_q <= settle_d;
    end
  end

  // Lamps, valves and diagnostics
  logic ctrl_en_q;
  logic bus_lamp_q, bus_lamp_d, logic_lamp_q, logic_lamp_d, valve_lamp_q, valve_lamp_d;
  logic branch_lamp_q, branch_lamp_d, busy_q, busy_d;
  logic [NV-1:0] valve_q, valve_d;
  logic [nsl_pkg::DIAG_W-1:0] diag_q, diag_d;

  always_comb begin
    bus_lamp_d = 1'b0;
    unique case (mode_q)
      nsl_pkg::MODE_FAIL: bus_lamp_d = fast_b.level;
      nsl_pkg::MODE_NORMAL: begin
        if (station_bad) begin
          bus_lamp_d = fast_b.level;
        end else if (bus_fault) begin
          bus_lamp_d = slow_b.level;
        end else begin
          bus_lamp_d = 1'b0;
        end
      end
      nsl_pkg::MODE_BOOT, nsl_pkg::MODE_ARMED, nsl_pkg::MODE_TEST: bus_lamp_d = 1'b0;
    endcase
    logic_lamp_d = logic_ok_s;
    valve_lamp_d = v_ok_s ? 1'b1 : (v_low_s & slow_b.level);
    branch_lamp_d = start_phase ? (branch_chg_s & slow_b.level) : chain_s;
    if (mode_q == nsl_pkg::MODE_TEST) begin
      // Interlock enable and controller commands are both bypassed here
      valve_d = {NV{test_b.level}};
    end else begin
      valve_d = i_valve_cmd & {NV{ctrl_en_q}};
    end
    busy_d = start_phase;
    diag_d = start_phase ? '0 : {cfg_s, link_s, dup_s, chain_s, v_low_s, !v_ok_s};
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      bus_lamp_q <= 1'b0;
      logic_lamp_q <= 1'b0;
      valve_lamp_q <= 1'b0;
      branch_lamp_q <= 1'b0;
      valve_q <= '0;
      busy_q <= 1'b1;
      diag_q <= '0;
    end else begin
      bus_lamp_q <= bus_lamp_d;
      logic_lamp_q <= logic_lamp_d;
      valve_lamp_q <= valve_lamp_d;
      branch_lamp_q <= branch_lamp_d;
      valve_q <= valve_d;
      busy_q <= busy_d;
      diag_q <= diag_d;
    end
  end

  // Events, mask and register slave
  logic [EW-1:0] cond, cond_q, ev_q, ev_d, mask_q, mask_d;
  logic ctrl_en_d;
  logic [31:0] rdata_q, rdata_d;

  assign cond[nsl_pkg::EV_STATION] = (mode_q == nsl_pkg::MODE_NORMAL) && station_bad;
  assign cond[nsl_pkg::EV_BUS] = (mode_q == nsl_pkg::MODE_NORMAL) && bus_fault;
  assign cond[nsl_pkg::EV_VLOW] = v_low_s && !v_ok_s;
  assign cond[nsl_pkg::EV_CHAIN] = !start_phase && chain_s;
  assign cond[nsl_pkg::EV_TEST] = (mode_q == nsl_pkg::MODE_TEST);
  assign cond[nsl_pkg::EV_FAIL] = (mode_q == nsl_pkg::MODE_FAIL);

  always_comb begin
    ev_d = ev_q;
    mask_d = mask_q;
    ctrl_en_d = ctrl_en_q;
    rdata_d = 32'h0000_0000;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        nsl_pkg::REG_EVENT: ev_d = ev_q & ~i_reg_wdata[EW-1:0];
        nsl_pkg::REG_MASK: mask_d = i_reg_wdata[EW-1:0];
        nsl_pkg::REG_CTRL: ctrl_en_d = i_reg_wdata[nsl_pkg::CTRL_VALVE_EN_BIT];
        default: ;
      endcase
    end
    // A new event outweighs a clear in the same cycle
    ev_d = ev_d | (cond & ~cond_q);
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        nsl_pkg::REG_STATUS: begin
          rdata_d[nsl_pkg::ST_LAMP_LSB +: 4] = {branch_lamp_q, valve_lamp_q, logic_lamp_q, bus_lamp_q};
          rdata_d[nsl_pkg::ST_BUSY_BIT] = busy_q;
          rdata_d[nsl_pkg::ST_MODE_LSB +: 3] = mode_q;
        end
        nsl_pkg::REG_EVENT: rdata_d[EW-1:0] = ev_q;
        nsl_pkg::REG_MASK: rdata_d[EW-1:0] = mask_q;
        nsl_pkg::REG_CTRL: rdata_d[nsl_pkg::CTRL_VALVE_EN_BIT] = ctrl_en_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cond_q <= '0;
      ev_q <= nsl_pkg::EV_RST;
      mask_q <= nsl_pkg::MASK_RST;
      ctrl_en_q <= nsl_pkg::CTRL_VALVE_EN_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      cond_q <= cond;
      ev_q <= ev_d;
      mask_q <= mask_d;
      ctrl_en_q <= ctrl_en_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_irq = |(ev_q & mask_q);
  assign o_lamp_bus_err = bus_lamp_q;
  assign o_lamp_logic = logic_lamp_q;
  assign o_lamp_valve = valve_lamp_q;
  assign o_lamp_branch = branch_lamp_q;
  assign o_valve_out = valve_q;
  assign o_busy = busy_q;
  assign o_diag_faults = diag_q;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_armed_release;
    mode_q == nsl_pkg::MODE_ARMED && !dil1_s && !start_fault;
  endsequence

  sequence s_armed_fault;
    mode_q == nsl_pkg::MODE_ARMED && start_fault;
  endsequence

  station_fast_a: assert property (mode_q == nsl_pkg::MODE_NORMAL && station_bad
    |=> o_lamp_bus_err == $past(fast_b.level)) else $error("bus lamp not fast on bad station");
  bus_slow_a: assert property (mode_q == nsl_pkg::MODE_NORMAL && !station_bad && bus_fault
    |=> o_lamp_bus_err == $past(slow_b.level)) else $error("bus lamp not slow on bus fault");
  logic_lamp_a: assert property (##1 o_lamp_logic == $past(logic_ok_s)) else $error("logic lamp wrong");
  valve_lamp_a: assert property ((v_ok_s |=> o_lamp_valve)
    and (!v_ok_s && v_low_s |=> o_lamp_valve == $past(slow_b.level))) else $error("valve lamp wrong");
  branch_start_a: assert property (start_phase |=> o_lamp_branch == $past(branch_chg_s & slow_b.level))
    else $error("branch lamp wrong in start");
  branch_run_a: assert property (!start_phase |=> o_lamp_branch == $past(chain_s))
    else $error("branch lamp wrong in operation");
  fault_free_a: assert property (mode_q == nsl_pkg::MODE_NORMAL && !station_bad && !bus_fault
    |=> !o_lamp_bus_err) else $error("bus lamp lit without fault");
  valves_together_a: assert property (mode_q == nsl_pkg::MODE_TEST ##1 mode_q == nsl_pkg::MODE_TEST
    |-> (o_valve_out == {NV{1'b1}} || o_valve_out == {NV{1'b0}})) else $error("valves not together");
  valve_toggle_a: assert property (mode_q == nsl_pkg::MODE_TEST && $past(mode_q, 2) == nsl_pkg::MODE_TEST
    && $changed(o_valve_out) |-> $past(test_b.tick)) else $error("valve toggle off its tick");
  test_entry_a: assert property (s_armed_release |=> (mode_q == nsl_pkg::MODE_TEST) [*2])
    else $error("test not entered");
  start_fail_a: assert property (s_armed_fault |=> mode_q == nsl_pkg::MODE_FAIL
    ##1 (o_valve_out == $past(i_valve_cmd & {NV{ctrl_en_q}}) && o_lamp_bus_err == $past(fast_b.level)))
    else $error("failed start not flagged");
  interlock_a: assert property (mode_q == nsl_pkg::MODE_TEST && !ctrl_en_q
    |=> o_valve_out[0] == $past(test_b.level)) else $error("test valves blocked by interlock");
  test_hold_a: assert property (mode_q == nsl_pkg::MODE_TEST |=> mode_q == nsl_pkg::MODE_TEST)
    else $error("test left without power cycle");
  busy_zero_a: assert property (o_busy |-> o_diag_faults == '0) else $error("fault bits while busy");
  // Sticky status only clears and mask only changes on a write, so the level cannot drop by itself
  irq_level_a: assert property (!i_reg_wr |=> o_irq || !$past(o_irq))
    else $error("irq dropped without a write");
endmodule
`default_nettype wire

// file: nsl_pad_note.sv
// Pad-level glue unit, holds no logic at present
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: nsl_field_model.sv
// Field-side model: watches lamp and valve drives, times their toggles
`timescale 1ns/1ps
`default_nettype none
module nsl_field_model (
  input wire logic i_ref_clk,
  input wire logic i_clear,
  input wire logic [3:0] i_obs,
  input wire logic [nsl_pkg::NUM_VALVES-1:0] i_valves,
  output logic [3:0][15:0] o_half,
  output logic o_split
);
  // Longer than any flash half period the bench uses
  localparam logic [15:0] STEADY = 16'h0028;
  logic [3:0] prev_q;
  logic [3:0][15:0] cnt_q;
  // Half period is the edge count between two changes; a steady lamp keeps 0
  always @(posedge i_ref_clk) begin
    if (i_clear) begin
      prev_q <= i_obs;
      cnt_q <= '0;
      o_half <= '0;
      o_split <= 1'b0;
    end else begin
      prev_q <= i_obs;
      for (int k = 0; k < 4; k++) begin
        if (i_obs[k] !== prev_q[k]) begin
          o_half[k] <= cnt_q[k] + 16'h0001;
          cnt_q[k] <= 16'h0000;
        end else begin
          cnt_q[k] <= cnt_q[k] + 16'h0001;
          if (cnt_q[k] == STEADY) begin
            o_half[k] <= 16'h0000;
          end
        end
      end
      // Valves must never disagree with each other during the test
      if (i_valves !== {nsl_pkg::NUM_VALVES{1'b0}} && i_valves !== {nsl_pkg::NUM_VALVES{1'b1}}) begin
        o_split <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the node status lamps and valve test block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned FH = 4;
  localparam int unsigned SH = 16;
  localparam int unsigned TH = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup_ok = 1'b1, v_ok = 1'b1, v_low = 1'b0, dil1 = 1'b1, started = 1'b1;
  logic dup = 1'b0, link = 1'b0, cfg = 1'b0, br_chg = 1'b0, chain = 1'b0, tfault = 1'b0;
  logic [7:0] station = 8'h05;
  logic [7:0] addr = 8'h00;
  logic [15:0] cmd = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0, rd = 1'b0;
  logic [31:0] rdata, rv;
  logic l_bus, l_logic, l_valve, l_branch, busy, irq, split;
  logic [15:0] valves;
  logic [5:0] diag;
  logic [3:0][15:0] half;
  logic [7:0] stn_tab [5] = '{8'h00, 8'h7E, 8'hC7, 8'h01, 8'h7D};
  int fails = 0, checks = 0, cycles = 0;

  always #50 clk = ~clk;

  nsl_node_status #(.FAST_HALF_CYCLES(FH), .SLOW_HALF_CYCLES(SH), .TEST_HALF_CYCLES(TH)) dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_logic_supply_ok(sup_ok), .i_valve_v_ok(v_ok),
    .i_valve_v_low(v_low), .i_station_num(station), .i_dil1_on(dil1), .i_bus_dup_addr(dup),
    .i_bus_link_fail(link), .i_cfg_mismatch(cfg), .i_startup_done(started),
    .i_branch_changed(br_chg), .i_chain_broken(chain), .i_test_fault(tfault), .i_valve_cmd(cmd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .o_lamp_bus_err(l_bus), .o_lamp_logic(l_logic), .o_lamp_valve(l_valve),
    .o_lamp_branch(l_branch), .o_valve_out(valves), .o_busy(busy), .o_diag_faults(diag),
    .o_irq(irq));

  nsl_field_model field (
    .i_ref_clk(clk), .i_clear(rst), .i_obs({valves[0], l_branch, l_valve, l_bus}),
    .i_valves(valves), .o_half(half), .o_split(split));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask
  task automatic finish_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Healthy field conditions; callers override at the following edge
  task automatic norm;
    @(posedge clk);
    {sup_ok, v_ok, v_low, started, dup, link, cfg, br_chg, chain, tfault} <= 10'b11_0100_0000;
    cmd <= 16'h0000;
    @(posedge clk);
  endtask
  // Switches are strapped during reset, as a power cycle would
  task automatic rst_dut(input logic [7:0] stn, input logic dil);
    @(posedge clk);
    station <= stn;
    dil1 <= dil;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(12);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Starting phase: busy, no fault detail, branch change flashes
    norm();
    started <= 1'b0;
    v_ok <= 1'b0;
    chain <= 1'b1;
    br_chg <= 1'b1;
    rst_dut(8'h05, 1'b1);
    settle(3 * SH);
    chk_pin({busy, diag}, 32'h40);
    chk_pin(half[2], SH);
    chk_pin(l_valve, 0);
    started <= 1'b1;
    settle(3 * SH);
    chk_pin({busy, diag}, 32'h05);
    chk_pin({l_branch, half[2] == 16'h0000}, 32'h3);
    // Fault-free operation, register map, interrupt
    norm();
    rst_dut(8'h05, 1'b1);
    settle(8);
    chk_pin({l_branch, l_valve, l_logic, l_bus}, 32'h6);
    reg_rd(nsl_pkg::REG_STATUS, rv);
    chk_reg(rv, 32'h0000_0106);
    reg_rd(nsl_pkg::REG_EVENT, rv);
    chk_reg(rv, 32'h0);
    reg_rd(nsl_pkg::REG_CTRL, rv);
    chk_reg(rv, 32'h0);
    reg_wr(nsl_pkg::REG_MASK, 32'hFFFF_FFFF);
    reg_rd(nsl_pkg::REG_MASK, rv);
    chk_reg(rv, 32'h0000_003F);
    reg_wr(nsl_pkg::REG_MASK, 32'h0);
    reg_wr(8'h10, 32'hFFFF_FFFF);
    reg_rd(8'h10, rv);
    chk_reg(rv, 32'h0);
    v_ok <= 1'b0;
    v_low <= 1'b1;
    chain <= 1'b1;
    sup_ok <= 1'b0;
    settle(3 * SH);
    chk_pin(half[1], SH);
    chk_pin({l_logic, l_branch, irq}, 32'h2);
    reg_rd(nsl_pkg::REG_EVENT, rv);
    chk_reg(rv, 32'h0000_000C);
    reg_wr(nsl_pkg::REG_MASK, 32'h0000_0008);
    settle(1);
    chk_pin(irq, 1);
    reg_wr(nsl_pkg::REG_EVENT, 32'h0000_0008);
    reg_rd(nsl_pkg::REG_EVENT, rv);
    chk_reg(rv, 32'h0000_0004);
    chk_pin(irq, 0);
    v_low <= 1'b0;
    settle(8);
    chk_pin({l_valve, half[1] == 16'h0000}, 32'h0);
    // Station range: fast flash outside 1..125
    for (int i = 0; i < 5; i++) begin
      norm();
      rst_dut(stn_tab[i], 1'b0);
      settle(3 * SH);
      chk_pin({half[0], l_bus && i > 2}, i < 3 ? FH * 2 : 0);
    end
    // Each bus fault cause gives the slow flash
    for (int k = 0; k < 3; k++) begin
      norm();
      rst_dut(8'h05, 1'b1);
      {cfg, link, dup} <= 3'b001 << k;
      settle(3 * SH);
      chk_pin(half[0], SH);
      chk_pin(diag, 6'h08 << k);
    end
    // Normal valve drive gated by the interlock bit
    norm();
    cmd <= 16'hA5C3;
    rst_dut(8'h05, 1'b1);
    chk_pin(valves, 16'h0000);
    reg_wr(nsl_pkg::REG_CTRL, 32'h1);
    settle(3);
    chk_pin(valves, 16'hA5C3);
    reg_rd(nsl_pkg::REG_CTRL, rv);
    chk_reg(rv, 32'h1);
    // Valve self-test entry, run and persistence
    norm();
    cmd <= 16'h1234;
    rst_dut(8'hC7, 1'b1);
    reg_rd(nsl_pkg::REG_STATUS, rv);
    chk_reg(rv & 32'h700, 32'h200);
    dil1 <= 1'b0;
    settle(6);
    reg_rd(nsl_pkg::REG_STATUS, rv);
    chk_reg(rv & 32'h700, 32'h300);
    chk_pin(valves, 16'h0000);
    settle(3 * TH + 4);
    chk_pin({half[3], split, l_bus}, TH * 4);
    reg_rd(nsl_pkg::REG_EVENT, rv);
    chk_reg(rv, 32'h10);
    station <= 8'h05;
    dil1 <= 1'b1;
    settle(8);
    reg_rd(nsl_pkg::REG_STATUS, rv);
    chk_reg(rv & 32'h700, 32'h300);
    // Fault while the test starts: fast flash, no test
    norm();
    tfault <= 1'b1;
    rst_dut(8'hC7, 1'b1);
    dil1 <= 1'b0;
    settle(3 * SH);
    chk_pin(half[0], FH);
    chk_pin({half[3], valves}, 32'h0);
    reg_rd(nsl_pkg::REG_STATUS, rv);
    chk_reg(rv & 32'h700, 32'h400);
    reg_rd(nsl_pkg::REG_EVENT, rv);
    chk_reg(rv, 32'h20);
    finish_test();
  end
endmodule
`default_nettype wire
